//--- sys_irq_defines.vh
// Offsets, field positions and reset values of the interrupt and brownout block
`ifndef SYS_IRQ_DEFINES_VH
`define SYS_IRQ_DEFINES_VH

// Register byte offsets
`define OFS_PWR_MON 4'h0
`define OFS_PEND_A 4'h4
`define OFS_PEND_B 4'h8
`define OFS_WAKEUP 4'hC

// Power-monitor control fields
`define BIT_BO_FLAG 7
`define BIT_BO_ACK 6
`define BIT_BO_IRQ_EN 5
`define BIT_BO_RST_EN 4
`define BIT_BO_STOP_EN 3
`define BIT_BO_DET_EN 2
`define BIT_BG_BUF_EN 0

// Pending and mask fields
`define BIT_GLOBAL_MASK 7

// Wakeup status fields
`define BIT_WK_FLAG 7
`define BIT_WK_ACK 6

// Reset values
`define RST_PWR_MON 8'h00
`define RST_PEND_A 8'h00
`define RST_PEND_B 8'h80
`define RST_WAKEUP 8'h00

// Bus answers
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

//--- sys_irq_pending_and_lvd_ctrl.v
// Interrupt pending aggregation and brownout control with an AXI4-Lite slave
// Operation
// - Enabled detector sets read-only brownout flag, bit 7, on a low-voltage event.
// - Writing 1 to acknowledge bit 6 clears the flag; bit 6 reads 0.
// - Interrupt enable bit 5 requests an interrupt while the flag is 1.
// - Flag forces chip reset when write-once reset enable and detector enable set.
// - Stop-enable bit 3 keeps detection running in stop mode, else disabled.
// - Write-once detector enable bit 2 turns detection on and gates other bits.
// - Write-once bits accept only the first write after reset.
// - Bit 0 enables the buffered bandgap reference for comparator and converter.
// - Pending A bit 7 shows pending brownout interrupt, clears with the flag.
// - Pending A bits 6..0 mirror keypad, comparator, converter, I2C, timers, wakeup.
// - All pending bits clear on any reset.
// - Global mask 0 lets any pending bit request the CPU; 1 blocks.
// - Global mask is read/write, set by reset and by vector fetch.
// - Pending B bits 6,5,4 show PWM channel 0, channel 1, overflow.
// - Pending B bit 2 shows serial error until all error flags clear.
// - Pending B bit 1 shows serial receive until receive flags clear.
// - Pending B bit 0 shows serial transmit until transmit flags clear.
// - Writing 1 to wakeup acknowledge clears the wakeup flag; 0 does nothing.
//
// Register access over AXI4-Lite and the register addresses were left to the implementer.
`include "sys_irq_defines.vh"
`default_nettype none

module sys_irq_pending_and_lvd_ctrl #(
	parameter ADDR_W = 4
) (
	// Clock and reset
	input wire mclk,
	input wire rstn,
	// AXI4-Lite write address
	input wire [ADDR_W-1:0] awaddr,
	input wire [2:0] awprot,
	input wire awvalid,
	output reg awready,
	// AXI4-Lite write data
	input wire [31:0] wdata,
	input wire [3:0] wstrb,
	input wire wvalid,
	output reg wready,
	// AXI4-Lite write response
	output reg [1:0] bresp,
	output reg bvalid,
	input wire bready,
	// AXI4-Lite read address
	input wire [ADDR_W-1:0] araddr,
	input wire [2:0] arprot,
	input wire arvalid,
	output reg arready,
	// AXI4-Lite read data
	output reg [31:0] rdata,
	output reg [1:0] rresp,
	output reg rvalid,
	input wire rready,
	// Brownout detector and chip state
	input wire low_voltage_event,
	input wire stop_mode,
	output reg brownout_detector_on,
	output reg bandgap_buffer_enable,
	output reg chip_reset_req,
	// Wakeup timer
	input wire wakeup_timeout_event,
	// Peripheral flags
	input wire keypad_flag,
	input wire comparator_event_flag,
	input wire conversion_complete_flag,
	input wire two_wire_irq_flag,
	input wire modulo_timer_two_pending_overflow_flag,
	input wire modulo_timer_one_pending_overflow_flag,
	input wire channel_zero_flag,
	input wire channel_one_flag,
	input wire counter_overflow_flag,
	input wire overrun_flag,
	input wire noise_flag,
	input wire framing_error_flag,
	input wire parity_error_flag,
	input wire receive_full_flag,
	input wire idle_line_flag,
	input wire break_detect_flag,
	input wire receive_edge_flag,
	input wire transmit_empty_flag,
	input wire transmit_complete_flag,
	// CPU side
	input wire vector_taken,
	output reg cpu_irq
);

////////////////////////////////////////////////////////////////////////////////
// State

reg aw_full_q;
reg w_full_q;
reg [ADDR_W-1:0] wr_addr_q;
reg [7:0] wr_data_q;
reg wr_lane0_q;

reg brownout_flag_q;
reg brownout_irq_enable_q;
reg brownout_reset_enable_q;
reg brownout_stop_enable_q;
reg brownout_detector_enable_q;
reg bandgap_buffer_enable_q;
reg reset_en_written_q;
reg det_en_written_q;
reg wakeup_timeout_flag_q;
reg global_interrupt_mask_q;
reg [6:0] pend_a_q;
reg [6:0] pend_b_q;

wire wr_go;
wire wr_pwr;
wire wr_pend_b;
wire wr_wk;
wire det_active;
wire [7:0] pend_a_d;
wire [7:0] pend_b_d;
reg [7:0] rd_byte_d;
reg rd_hit_d;

////////////////////////////////////////////////////////////////////////////////
// Write decode

assign wr_go = aw_full_q && w_full_q && !bvalid;
assign wr_pwr = wr_go && wr_lane0_q && (wr_addr_q == `OFS_PWR_MON);
assign wr_pend_b = wr_go && wr_lane0_q && (wr_addr_q == `OFS_PEND_B);
assign wr_wk = wr_go && wr_lane0_q && (wr_addr_q == `OFS_WAKEUP);

////////////////////////////////////////////////////////////////////////////////
// Write channels

always @(posedge mclk or negedge rstn) begin
	if (!rstn) begin
		awready <= 1'b1;
		wready <= 1'b1;
		aw_full_q <= 1'b0;
		w_full_q <= 1'b0;
		wr_addr_q <= {ADDR_W{1'b0}};
		wr_data_q <= 8'h00;
		wr_lane0_q <= 1'b0;
		bvalid <= 1'b0;
		bresp <= `RESP_OKAY;
	end else begin
		if (awvalid && awready) begin
			awready <= 1'b0;
			aw_full_q <= 1'b1;
			wr_addr_q <= awaddr;
		end
		if (wvalid && wready) begin
			wready <= 1'b0;
			w_full_q <= 1'b1;
			wr_data_q <= wdata[7:0];
			wr_lane0_q <= wstrb[0];
		end
		if (wr_go) begin
			aw_full_q <= 1'b0;
			w_full_q <= 1'b0;
			bvalid <= 1'b1;
			if (wr_addr_q == `OFS_PWR_MON || wr_addr_q == `OFS_PEND_A ||
				wr_addr_q == `OFS_PEND_B || wr_addr_q == `OFS_WAKEUP) begin
				bresp <= `RESP_OKAY;
			end else begin
				bresp <= `RESP_SLVERR;
			end
		end
		if (bvalid && bready) begin
			bvalid <= 1'b0;
			awready <= 1'b1;
			wready <= 1'b1;
		end
	end
end

////////////////////////////////////////////////////////////////////////////////
// Brownout control

assign det_active = brownout_detector_enable_q && (!stop_mode || brownout_stop_enable_q);

always @(posedge mclk or negedge rstn) begin
	if (!rstn) begin
		brownout_flag_q <= 1'b0;
		brownout_irq_enable_q <= 1'b0;
		brownout_reset_enable_q <= 1'b0;
		brownout_stop_enable_q <= 1'b0;
		brownout_detector_enable_q <= 1'b0;
		bandgap_buffer_enable_q <= 1'b0;
		reset_en_written_q <= 1'b0;
		det_en_written_q <= 1'b0;
	end else begin
		if (wr_pwr) begin
			brownout_irq_enable_q <= wr_data_q[`BIT_BO_IRQ_EN];
			brownout_stop_enable_q <= wr_data_q[`BIT_BO_STOP_EN];
			bandgap_buffer_enable_q <= wr_data_q[`BIT_BG_BUF_EN];
			if (!reset_en_written_q) begin
				brownout_reset_enable_q <= wr_data_q[`BIT_BO_RST_EN];
				reset_en_written_q <= 1'b1;
			end
			if (!det_en_written_q) begin
				brownout_detector_enable_q <= wr_data_q[`BIT_BO_DET_EN];
				det_en_written_q <= 1'b1;
			end
		end
		if (det_active && low_voltage_event) begin
			brownout_flag_q <= 1'b1;
		end else if (wr_pwr && wr_data_q[`BIT_BO_ACK]) begin
			brownout_flag_q <= 1'b0;
		end
	end
end

////////////////////////////////////////////////////////////////////////////////
// Wakeup timer flag

always @(posedge mclk or negedge rstn) begin
	if (!rstn) begin
		wakeup_timeout_flag_q <= 1'b0;
	end else begin
		if (wakeup_timeout_event) begin
			wakeup_timeout_flag_q <= 1'b1;
		end else if (wr_wk && wr_data_q[`BIT_WK_ACK]) begin
			wakeup_timeout_flag_q <= 1'b0;
		end
	end
end

////////////////////////////////////////////////////////////////////////////////
// Pending mirrors

assign pend_a_d = {
	brownout_flag_q && brownout_irq_enable_q && brownout_detector_enable_q,
	keypad_flag,
	comparator_event_flag,
	conversion_complete_flag,
	two_wire_irq_flag,
	modulo_timer_two_pending_overflow_flag,
	modulo_timer_one_pending_overflow_flag,
	wakeup_timeout_flag_q
};

assign pend_b_d = {
	1'b0,
	channel_zero_flag,
	channel_one_flag,
	counter_overflow_flag,
	1'b0,
	overrun_flag || noise_flag || framing_error_flag || parity_error_flag,
	receive_full_flag || idle_line_flag || break_detect_flag || receive_edge_flag,
	transmit_empty_flag || transmit_complete_flag
};

always @(posedge mclk or negedge rstn) begin
	if (!rstn) begin
		pend_a_q <= 7'h00;
		pend_b_q <= 7'h00;
	end else begin
		pend_a_q <= pend_a_d[6:0];
		pend_b_q <= pend_b_d[6:0];
	end
end

reg pend_bo_q;

always @(posedge mclk or negedge rstn) begin
	if (!rstn) begin
		pend_bo_q <= 1'b0;
	end else begin
		pend_bo_q <= pend_a_d[7];
	end
end

////////////////////////////////////////////////////////////////////////////////
// Global mask and CPU request

always @(posedge mclk or negedge rstn) begin
	if (!rstn) begin
		global_interrupt_mask_q <= 1'b1;
	end else begin
		if (vector_taken) begin
			global_interrupt_mask_q <= 1'b1;
		end else if (wr_pend_b) begin
			global_interrupt_mask_q <= wr_data_q[`BIT_GLOBAL_MASK];
		end
	end
end

always @(posedge mclk or negedge rstn) begin
	if (!rstn) begin
		cpu_irq <= 1'b0;
		chip_reset_req <= 1'b0;
		brownout_detector_on <= 1'b0;
		bandgap_buffer_enable <= 1'b0;
	end else begin
		cpu_irq <= !global_interrupt_mask_q && ((|pend_a_d) || (|pend_b_d));
		chip_reset_req <= brownout_flag_q && brownout_reset_enable_q &&
			brownout_detector_enable_q;
		brownout_detector_on <= det_active;
		bandgap_buffer_enable <= bandgap_buffer_enable_q;
	end
end

////////////////////////////////////////////////////////////////////////////////
// Read decode

always @* begin
	rd_byte_d = 8'h00;
	rd_hit_d = 1'b1;
	if (araddr == `OFS_PWR_MON) begin
		rd_byte_d = {brownout_flag_q, 1'b0, brownout_irq_enable_q,
			brownout_reset_enable_q, brownout_stop_enable_q,
			brownout_detector_enable_q, 1'b0, bandgap_buffer_enable_q};
	end else if (araddr == `OFS_PEND_A) begin
		rd_byte_d = {pend_bo_q, pend_a_q};
	end else if (araddr == `OFS_PEND_B) begin
		rd_byte_d = {global_interrupt_mask_q, pend_b_q};
	end else if (araddr == `OFS_WAKEUP) begin
		rd_byte_d = {wakeup_timeout_flag_q, 7'h00};
	end else begin
		rd_hit_d = 1'b0;
	end
end

////////////////////////////////////////////////////////////////////////////////
// Read channels

always @(posedge mclk or negedge rstn) begin
	if (!rstn) begin
		arready <= 1'b1;
		rvalid <= 1'b0;
		rdata <= 32'h0000_0000;
		rresp <= `RESP_OKAY;
	end else begin
		if (arvalid && arready) begin
			arready <= 1'b0;
			rvalid <= 1'b1;
			rdata <= {24'h00_0000, rd_byte_d};
			rresp <= rd_hit_d ? `RESP_OKAY : `RESP_SLVERR;
		end
		if (rvalid && rready) begin
			rvalid <= 1'b0;
			arready <= 1'b1;
		end
	end
end

endmodule // sys_irq_pending_and_lvd_ctrl

`default_nettype wire

//--- sys_irq_monitor.sv
// Bus handshake and interrupt output checks
`default_nettype none
module sys_irq_monitor (
	// Clock and reset
	input wire logic mclk,
	input wire logic rstn,
	// Bus
	input wire logic awvalid,
	input wire logic awready,
	input wire logic wvalid,
	input wire logic wready,
	input wire logic bvalid,
	input wire logic bready,
	input wire logic arvalid,
	input wire logic arready,
	input wire logic rvalid,
	input wire logic rready,
	input wire logic [31:0] rdata,
	// Core side
	input wire logic chip_reset_req,
	input wire logic vector_taken,
	input wire logic cpu_irq
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!rstn);
	b_answer_a: assert property (awvalid && awready && wvalid && wready |-> ##2 bvalid)
		else $error("no write answer");
	r_answer_a: assert property (arvalid && arready |=> rvalid)
		else $error("no read answer");
	b_done_a: assert property (bvalid && bready |=> !bvalid)
		else $error("write answer stuck");
	r_done_a: assert property (rvalid && rready |=> !rvalid)
		else $error("read answer stuck");
	busy_stall_a: assert property (bvalid |-> !awready && !wready)
		else $error("write taken while busy");
	upper_zero_a: assert property (rvalid |-> rdata[31:8] == 24'h0)
		else $error("upper read bits set");
	reset_quiet_a: assert property ($rose(rstn) |-> !cpu_irq && !chip_reset_req)
		else $error("outputs active after reset");
	mask_vector_a: assert property (vector_taken |=> ##1 !cpu_irq)
		else $error("request after vector");
	cover property (cpu_irq);
	cover property (chip_reset_req);
	cover property (vector_taken && cpu_irq);
endmodule // sys_irq_monitor
bind sys_irq_pending_and_lvd_ctrl sys_irq_monitor i_mon (
	.mclk(mclk), .rstn(rstn), .awvalid(awvalid), .awready(awready), .wvalid(wvalid),
	.wready(wready), .bvalid(bvalid), .bready(bready), .arvalid(arvalid), .arready(arready),
	.rvalid(rvalid), .rready(rready), .rdata(rdata), .chip_reset_req(chip_reset_req),
	.vector_taken(vector_taken), .cpu_irq(cpu_irq)
);
`default_nettype wire

//--- periph_model.sv
// Peripheral flag sources and CPU vector fetch model
`default_nettype none
module periph_model (
	// Clock and reset
	input wire logic mclk,
	input wire logic rstn,
	// Bench commands
	input wire logic [18:0] req,
	input wire logic take_en,
	// Device side
	input wire logic cpu_irq,
	output logic [18:0] flags,
	output logic vector_taken
);
	timeunit 1ns;
	timeprecision 1ps;
	always @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			flags <= 19'h0;
			vector_taken <= 1'b0;
		end else begin
			flags <= req;
			vector_taken <= take_en && cpu_irq && !vector_taken;
		end
	end
endmodule // periph_model
`default_nettype wire

//--- sys_irq_pending_and_lvd_ctrl_bench.sv
// Register, brownout and pending interrupt tests
`include "sys_irq_defines.vh"
`default_nettype none
module sys_irq_pending_and_lvd_ctrl_bench;
	timeunit 1ns;
	timeprecision 1ps;
	logic mclk, rstn, awvalid, awready, wvalid, wready, bvalid, arvalid, arready, rvalid;
	logic lv, stop, det_on, bg_on, crst, wk, take_en, vec, cpu_irq;
	logic bready, rready;
	logic [3:0] strb;
	logic [4:0] awaddr, araddr;
	logic [31:0] wdata, rdata, q;
	logic [1:0] bresp, rresp;
	logic [18:0] req, flg;
	int fails, samples_checked, cyc, b;
	sys_irq_pending_and_lvd_ctrl #(.ADDR_W(5)) i_dut (
		.mclk(mclk), .rstn(rstn), .awaddr(awaddr), .awprot(3'h0), .awvalid(awvalid),
		.awready(awready), .wdata(wdata), .wstrb(strb), .wvalid(wvalid), .wready(wready),
		.bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arprot(3'h0),
		.arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
		.rready(rready), .low_voltage_event(lv), .stop_mode(stop), .brownout_detector_on(det_on),
		.bandgap_buffer_enable(bg_on), .chip_reset_req(crst), .wakeup_timeout_event(wk),
		.keypad_flag(flg[0]), .comparator_event_flag(flg[1]), .conversion_complete_flag(flg[2]),
		.two_wire_irq_flag(flg[3]), .modulo_timer_two_pending_overflow_flag(flg[4]), .modulo_timer_one_pending_overflow_flag(flg[5]),
		.channel_zero_flag(flg[6]), .channel_one_flag(flg[7]), .counter_overflow_flag(flg[8]),
		.overrun_flag(flg[9]), .noise_flag(flg[10]), .framing_error_flag(flg[11]),
		.parity_error_flag(flg[12]), .receive_full_flag(flg[13]), .idle_line_flag(flg[14]),
		.break_detect_flag(flg[15]), .receive_edge_flag(flg[16]), .transmit_empty_flag(flg[17]),
		.transmit_complete_flag(flg[18]), .vector_taken(vec), .cpu_irq(cpu_irq)
	);
	periph_model i_peer (.mclk(mclk), .rstn(rstn), .req(req), .take_en(take_en),
		.cpu_irq(cpu_irq), .flags(flg), .vector_taken(vec));
	////////////////////////////////////////////////////////////////////////////////
	task automatic final_report;
		if (fails == 0 && samples_checked > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
		samples_checked++;
		if (s !== e) begin
			fails++;
			$display("ERROR %s expected %h seen %h", nm, e, s);
		end
	endtask
	task automatic w3;
		repeat (3) @(posedge mclk);
	endtask
	task automatic wr(input logic [4:0] a, input logic [7:0] d);
		awaddr <= a;
		wdata <= {24'h0, d};
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge mclk);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
		end while (!bvalid);
		bready <= 1'b0;
		@(posedge mclk);
	endtask
	task automatic rd(input logic [4:0] a);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge mclk);
			if (arready) arvalid <= 1'b0;
		end while (!rvalid);
		q = rdata;
		rready <= 1'b0;
		@(posedge mclk);
	endtask
	task automatic rc(input logic [4:0] a, input logic [7:0] e);
		rd(a);
		chk($sformatf("reg %h", a), q, {24'h0, e});
	endtask
	task automatic lvp;
		lv <= 1'b1;
		@(posedge mclk);
		lv <= 1'b0;
		w3;
	endtask
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		mclk = 1'b0;
		forever #2.5 mclk = ~mclk;
	end
	always @(posedge mclk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			fails++;
			final_report;
		end
	end
	initial begin
		rstn = 1'b0;
		{awvalid, wvalid, bready, arvalid, rready, lv, stop, wk, take_en} = 9'h000;
		strb = 4'hF;
		awaddr = 5'h00;
		araddr = 5'h00;
		wdata = 32'h0;
		req = 19'h0;
		repeat (4) @(posedge mclk);
		rstn <= 1'b1;
		@(posedge mclk);
		rc(`OFS_PWR_MON, `RST_PWR_MON);
		rc(`OFS_PEND_A, `RST_PEND_A);
		rc(`OFS_PEND_B, `RST_PEND_B);
		rd(5'h10);
		chk("unmapped resp", rresp, `RESP_SLVERR);
		wr(5'h10, 8'hFF);
		chk("unmapped bresp", bresp, `RESP_SLVERR);
		wr(`OFS_PWR_MON, 8'hFF);
		chk("bresp", bresp, `RESP_OKAY);
		rc(`OFS_PWR_MON, 8'h3D);
		chk("bandgap", bg_on, 1'b1);
		chk("detector", det_on, 1'b1);
		wr(`OFS_PWR_MON, 8'h00);
		rc(`OFS_PWR_MON, 8'h14);
		wr(`OFS_PWR_MON, 8'h21);
		rc(`OFS_PWR_MON, 8'h35);
		lvp;
		rc(`OFS_PWR_MON, 8'hB5);
		rc(`OFS_PEND_A, 8'h80);
		chk("reset req", crst, 1'b1);
		wr(`OFS_PEND_B, 8'h00);
		w3;
		chk("irq", cpu_irq, 1'b1);
		take_en <= 1'b1;
		w3;
		take_en <= 1'b0;
		w3;
		chk("irq", cpu_irq, 1'b0);
		rc(`OFS_PEND_B, 8'h80);
		wr(`OFS_PEND_B, 8'h00);
		wr(`OFS_PWR_MON, 8'h61);
		w3;
		rc(`OFS_PWR_MON, 8'h35);
		rc(`OFS_PEND_A, 8'h00);
		chk("irq", cpu_irq, 1'b0);
		chk("reset req", crst, 1'b0);
		stop <= 1'b1;
		w3;
		chk("detector", det_on, 1'b0);
		lvp;
		rc(`OFS_PWR_MON, 8'h35);
		wr(`OFS_PWR_MON, 8'h39);
		w3;
		chk("detector", det_on, 1'b1);
		lvp;
		rc(`OFS_PWR_MON, 8'hBD);
		chk("reset req", crst, 1'b1);
		wr(`OFS_PWR_MON, 8'h79);
		rc(`OFS_PWR_MON, 8'h3D);
		stop <= 1'b0;
		for (int i = 0; i < 19; i++) begin
			req <= 19'h1 << i;
			w3;
			b = (i < 6) ? 6 - i : (i < 9) ? 12 - i : (i < 13) ? 2 : (i < 17) ? 1 : 0;
			rc((i < 6) ? `OFS_PEND_A : `OFS_PEND_B, 8'h01 << b);
			chk("irq", cpu_irq, 1'b1);
			req <= 19'h0;
			w3;
			chk("irq", cpu_irq, 1'b0);
		end
		wk <= 1'b1;
		@(posedge mclk);
		wk <= 1'b0;
		w3;
		rc(`OFS_PEND_A, 8'h01);
		wr(`OFS_WAKEUP, 8'h00);
		rc(`OFS_WAKEUP, 8'h80);
		wr(`OFS_WAKEUP, 8'h40);
		rc(`OFS_WAKEUP, 8'h00);
		chk("irq", cpu_irq, 1'b0);
		req <= 19'h1;
		w3;
		rstn <= 1'b0;
		repeat (2) @(posedge mclk);
		rstn <= 1'b1;
		req <= 19'h0;
		@(posedge mclk);
		chk("irq", cpu_irq, 1'b0);
		rc(`OFS_PEND_A, `RST_PEND_A);
		rc(`OFS_PEND_B, `RST_PEND_B);
		rc(`OFS_PWR_MON, `RST_PWR_MON);
		strb <= 4'h0;
		wr(`OFS_PWR_MON, 8'h04);
		chk("bresp", bresp, `RESP_OKAY);
		rc(`OFS_PWR_MON, 8'h00);
		strb <= 4'hF;
		wr(`OFS_PWR_MON, 8'h00);
		wr(`OFS_PWR_MON, 8'h04);
		rc(`OFS_PWR_MON, 8'h00);
		lvp;
		rc(`OFS_PWR_MON, 8'h00);
		final_report;
	end
endmodule // sys_irq_pending_and_lvd_ctrl_bench
`default_nettype wire
